//--- hdl/lovs_top.sv
// led overvoltage start-up supervisor with apb registers
// What this block does
// - standby while enable low, run while high
// - standalone dither off, on if sdi high
// - recovery flag held while supply low
// - converter stopped during start-up hold window
// - flag cleared at clean recovery window end
// - later overvoltage latched until status read-clear
// - overvoltage in window: discharge, then release
// - late dimming rise starts the recovery window
// - run overvoltage: latch, discharge, stop converter
// - battery overvoltage masks led overvoltage handling
// - battery overvoltage end then latch, discharge
// - recovery time accumulates across dimming pulses
// - trip level forces both gate drives off
// - overvoltage shown in status bits 7, 18
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "lovs_params.svh"
module lovs_top
  import lovs_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES  = `LOVS_HOLD_CYCLES,
  parameter int unsigned RECOV_CYCLES = `LOVS_RECOV_CYCLES
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        enable_pin,
  input  wire logic        sdi_pin,
  input  wire logic        standalone_mode,
  input  wire logic        supply_above_min,
  input  wire logic        dim_in,
  input  wire logic        led_ov_trip,
  input  wire logic        led_below_release,
  input  wire logic        batt_ov,
  output logic             standby,
  output logic             gate_drive_main,
  output logic             gate_drive_dimming,
  output logic             discharge_en,
  output logic             ov_recovery_flag,
  output logic             dither_en,
  output logic             irq
);
  import lovs_pkg::*;

  localparam lovs_cnt_t HOLD_LAST  = lovs_cnt_t'(HOLD_CYCLES - 1);
  localparam lovs_cnt_t RECOV_LAST = lovs_cnt_t'(RECOV_CYCLES - 1);

  lovs_regs_s              r_reg;
  lovs_regs_s              r_next;
  logic [`LOVS_SYNC_W-1:0] pins_sync;
  logic                    en_s;
  logic                    sdi_s;
  logic                    alone_s;
  logic                    sup_s;
  logic                    dim_s;
  logic                    trip_s;
  logic                    rel_s;
  logic                    batt_s;
  logic                    alive;
  logic                    ev_ov;
  logic                    win_done;
  logic                    run;
  logic                    setup_ph;
  logic                    wr_acc;
  logic                    rd_sr1;
  logic                    mapped;
  logic [31:0]             rd_val;
  logic [`LOVS_IRQ_W-1:0]  irq_ev;
  logic [`LOVS_IRQ_W-1:0]  w1c;

  lovs_sync u_sync
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .pins_in   ({enable_pin, sdi_pin, standalone_mode, supply_above_min,
                 dim_in, led_ov_trip, led_below_release, batt_ov}),
    .pins_sync (pins_sync)
  );

  assign {en_s, sdi_s, alone_s, sup_s, dim_s, trip_s, rel_s, batt_s} = pins_sync;
  assign alive    = sup_s && en_s;
  assign ev_ov    = trip_s && !batt_s;
  assign win_done = (r_reg.rec_cnt == RECOV_LAST);
  assign setup_ph = psel && !penable;
  assign wr_acc   = psel && penable && pwrite;
  assign rd_sr1   = psel && penable && !pwrite && (paddr == `LOVS_OFF_SR1);

  always_comb
  begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      `LOVS_OFF_CTRL:     rd_val[`LOVS_CTRL_DITHER_BIT] = r_reg.ctrl_dither;
      `LOVS_OFF_SR1:      rd_val[`LOVS_SR1_OV_BIT] = r_reg.ov_latched;
      `LOVS_OFF_GSB:      rd_val[`LOVS_GSB_OV_BIT] = r_reg.ov_latched;
      `LOVS_OFF_IRQ_STAT: rd_val[`LOVS_IRQ_W-1:0] = r_reg.irq_stat;
      `LOVS_OFF_IRQ_MASK: rd_val[`LOVS_IRQ_W-1:0] = r_reg.irq_mask;
      `LOVS_OFF_STATE:    rd_val[7:0] = {r_reg.discharge, r_reg.rec_ov_seen,
                                         r_reg.rec_flag, 2'h0, r_reg.st};
      default:            mapped = 1'b0;
    endcase
  end

  always_comb
  begin
    r_next = r_reg;
    irq_ev = '0;
    w1c    = '0;
    r_next.dim_d  = dim_s;
    r_next.batt_d = batt_s;

    // discharge ends once the led voltage is under the release level
    if (r_reg.discharge && rel_s && !ev_ov)
      r_next.discharge = 1'b0;

    case (r_reg.st)
      ST_OFF:
      begin
        if (alive)
          r_next.st = ST_HOLD;
      end
      ST_HOLD:
      begin
        r_next.hold_cnt = r_reg.hold_cnt + lovs_cnt_t'(1);
        if (r_reg.hold_cnt == HOLD_LAST)
          r_next.st = dim_s ? ST_RECOV : ST_WAIT_DIM;
      end
      ST_WAIT_DIM:
      begin
        if (dim_s && !r_reg.dim_d)
          r_next.st = ST_RECOV;
      end
      ST_RECOV:
      begin
        // time with dimming high and no discharge counts, so short pulses add up
        if (dim_s && !r_reg.discharge && !win_done)
          r_next.rec_cnt = r_reg.rec_cnt + lovs_cnt_t'(1);
        if (ev_ov)
        begin
          r_next.rec_ov_seen = 1'b1;
          r_next.discharge   = 1'b1;
        end
        else if (win_done && (!r_reg.rec_ov_seen || !r_reg.discharge))
        begin
          r_next.rec_flag    = 1'b0;
          r_next.rec_ov_seen = 1'b0;
          r_next.st          = ST_RUN;
          irq_ev[`LOVS_IRQ_REC_BIT] = 1'b1;
        end
      end
      ST_RUN:
      begin
        if (ev_ov)
        begin
          r_next.ov_latched = 1'b1;
          r_next.discharge  = 1'b1;
        end
      end
      default:
        r_next.st = ST_OFF;
    endcase

    // read-and-clear of the first status register; a new event wins
    if (rd_sr1 && !(r_reg.st == ST_RUN && ev_ov))
      r_next.ov_latched = 1'b0;

    // supply undervoltage or standby behaves as an internal reset
    if (!alive)
    begin
      r_next.st          = ST_OFF;
      r_next.hold_cnt    = '0;
      r_next.rec_cnt     = '0;
      r_next.rec_flag    = 1'b1;
      r_next.rec_ov_seen = 1'b0;
      r_next.ov_latched  = 1'b0;
      r_next.discharge   = 1'b0;
    end

    irq_ev[`LOVS_IRQ_OV_BIT]   = r_next.discharge && !r_reg.discharge;
    irq_ev[`LOVS_IRQ_BATT_BIT] = batt_s && !r_reg.batt_d;

    // apb register writes and read data capture
    if (wr_acc && paddr == `LOVS_OFF_CTRL)
      r_next.ctrl_dither = pwdata[`LOVS_CTRL_DITHER_BIT];
    if (wr_acc && paddr == `LOVS_OFF_IRQ_MASK)
      r_next.irq_mask = pwdata[`LOVS_IRQ_W-1:0];
    if (wr_acc && paddr == `LOVS_OFF_IRQ_STAT)
      w1c = pwdata[`LOVS_IRQ_W-1:0];
    r_next.irq_stat = (r_reg.irq_stat & ~w1c) | irq_ev;
    if (setup_ph)
    begin
      r_next.prdata  = rd_val;
      r_next.pslverr = !mapped;
    end

    // gate drives registered; stop terms come straight from synced pins
    run = (r_reg.st == ST_RUN || r_reg.st == ST_RECOV) && dim_s && alive
          && !r_reg.ov_latched && !r_reg.discharge
          && !trip_s && !batt_s;
    r_next.gate_main = run;
    r_next.gate_dim  = run;
    r_next.standby   = !en_s;
    r_next.dither    = alone_s ? sdi_s : r_reg.ctrl_dither;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_reg             <= '0;
      r_reg.st          <= ST_OFF;
      r_reg.rec_flag    <= 1'b1;
      r_reg.standby     <= 1'b1;
      r_reg.ctrl_dither <= `LOVS_CTRL_RST;
      r_reg.irq_mask    <= `LOVS_IRQ_MASK_RST;
    end
    else
      r_reg <= r_next;
  end

  assign pready             = 1'b1;
  assign prdata             = r_reg.prdata;
  assign pslverr            = r_reg.pslverr && psel && penable;
  assign standby            = r_reg.standby;
  assign gate_drive_main    = r_reg.gate_main;
  assign gate_drive_dimming = r_reg.gate_dim;
  assign discharge_en       = r_reg.discharge;
  assign ov_recovery_flag   = r_reg.rec_flag;
  assign dither_en          = r_reg.dither;
  assign irq                = |(r_reg.irq_stat & r_reg.irq_mask);

  property p_standby;
    @(posedge pclk) disable iff (!presetn)
    !en_s |=> standby && !gate_drive_main;
  endproperty
  a_standby: assert property (p_standby) else $error("standby not entered");

  property p_dither;
    @(posedge pclk) disable iff (!presetn)
    alone_s |=> dither_en == $past(sdi_s);
  endproperty
  a_dither: assert property (p_dither) else $error("dither strap ignored");

  property p_rec_low_supply;
    @(posedge pclk) disable iff (!presetn)
    !sup_s |=> ov_recovery_flag && r_reg.rec_cnt == '0 && r_reg.hold_cnt == '0;
  endproperty
  a_rec_low_supply: assert property (p_rec_low_supply) else $error("supply low state");

  property p_hold_stop;
    @(posedge pclk) disable iff (!presetn)
    r_reg.st == ST_HOLD |=> !gate_drive_main && !gate_drive_dimming;
  endproperty
  a_hold_stop: assert property (p_hold_stop) else $error("gate on in hold");

  property p_clean_window;
    @(posedge pclk) disable iff (!presetn)
    r_reg.st == ST_RECOV && win_done && !r_reg.rec_ov_seen && alive && !ev_ov
      |=> !ov_recovery_flag && r_reg.st == ST_RUN;
  endproperty
  a_clean_window: assert property (p_clean_window) else $error("flag not cleared");

  property p_latched_stop;
    @(posedge pclk) disable iff (!presetn)
    r_reg.ov_latched |=> !gate_drive_main;
  endproperty
  a_latched_stop: assert property (p_latched_stop) else $error("gate on while latched");

  property p_release;
    @(posedge pclk) disable iff (!presetn)
    discharge_en && rel_s && !ev_ov |=> !discharge_en;
  endproperty
  a_release: assert property (p_release) else $error("discharge not released");

  property p_late_dim;
    @(posedge pclk) disable iff (!presetn)
    r_reg.st == ST_WAIT_DIM && dim_s && !r_reg.dim_d && alive |=> r_reg.st == ST_RECOV;
  endproperty
  a_late_dim: assert property (p_late_dim) else $error("late dim rise missed");

  property p_run_ov;
    @(posedge pclk) disable iff (!presetn)
    r_reg.st == ST_RUN && ev_ov && alive |=> r_reg.ov_latched && discharge_en;
  endproperty
  a_run_ov: assert property (p_run_ov) else $error("overvoltage not latched");

  property p_batt_mask;
    @(posedge pclk) disable iff (!presetn)
    batt_s && !r_reg.ov_latched |=> !r_reg.ov_latched;
  endproperty
  a_batt_mask: assert property (p_batt_mask) else $error("latched under batt ov");

  property p_batt_end;
    @(posedge pclk) disable iff (!presetn)
    r_reg.st == ST_RUN && r_reg.batt_d && !batt_s && trip_s && alive |=> r_reg.ov_latched;
  endproperty
  a_batt_end: assert property (p_batt_end) else $error("no latch after batt ov");

  property p_accumulate;
    @(posedge pclk) disable iff (!presetn)
    r_reg.st == ST_RECOV && dim_s && !r_reg.discharge && !win_done && alive
      |=> r_reg.rec_cnt == $past(r_reg.rec_cnt) + lovs_cnt_t'(1);
  endproperty
  a_accumulate: assert property (p_accumulate) else $error("recovery time lost");

  property p_trip_off;
    @(posedge pclk) disable iff (!presetn)
    trip_s |=> !gate_drive_main && !gate_drive_dimming;
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("gate on at trip");

endmodule
`default_nettype wire

//--- hdl/lovs_params.svh
// constants for the led overvoltage start-up supervisor
`ifndef LOVS_PARAMS_SVH
`define LOVS_PARAMS_SVH

`define LOVS_CLK_MHZ          125
`define LOVS_HOLD_US          5000
`define LOVS_RECOV_US         5000
`define LOVS_HOLD_CYCLES      (`LOVS_HOLD_US * `LOVS_CLK_MHZ)
`define LOVS_RECOV_CYCLES     (`LOVS_RECOV_US * `LOVS_CLK_MHZ)
`define LOVS_CNT_W            20
`define LOVS_SYNC_W           8

`define LOVS_OFF_CTRL         8'h00
`define LOVS_OFF_SR1          8'h04
`define LOVS_OFF_GSB          8'h08
`define LOVS_OFF_IRQ_STAT     8'h0C
`define LOVS_OFF_IRQ_MASK     8'h10
`define LOVS_OFF_STATE        8'h14

`define LOVS_CTRL_DITHER_BIT  0
`define LOVS_SR1_OV_BIT       18
`define LOVS_GSB_OV_BIT       7
`define LOVS_IRQ_W            3
`define LOVS_IRQ_OV_BIT       0
`define LOVS_IRQ_REC_BIT      1
`define LOVS_IRQ_BATT_BIT     2

`define LOVS_CTRL_RST         1'b0
`define LOVS_IRQ_MASK_RST     3'h0

`endif

//--- hdl/lovs_pkg.sv
// types of the led overvoltage start-up supervisor
`include "lovs_params.svh"
package lovs_pkg;

  typedef enum logic [2:0]
  {
    ST_OFF,
    ST_HOLD,
    ST_WAIT_DIM,
    ST_RECOV,
    ST_RUN
  } lovs_state_e;

  typedef logic [`LOVS_CNT_W-1:0] lovs_cnt_t;

  typedef struct packed
  {
    lovs_state_e                st;
    lovs_cnt_t                  hold_cnt;
    lovs_cnt_t                  rec_cnt;
    logic                       dim_d;
    logic                       batt_d;
    logic                       rec_flag;
    logic                       rec_ov_seen;
    logic                       ov_latched;
    logic                       discharge;
    logic                       ctrl_dither;
    logic [`LOVS_IRQ_W-1:0]     irq_mask;
    logic [`LOVS_IRQ_W-1:0]     irq_stat;
    logic [31:0]                prdata;
    logic                       pslverr;
    logic                       gate_main;
    logic                       gate_dim;
    logic                       standby;
    logic                       dither;
  } lovs_regs_s;

  typedef struct packed
  {
    logic [`LOVS_SYNC_W-1:0]    meta;
    logic [`LOVS_SYNC_W-1:0]    sync;
  } lovs_sync_s;

endpackage

//--- hdl/lovs_sync.sv
// two-flop synchroniser for the pin inputs
`timescale 1ns/1ps
`default_nettype none
`include "lovs_params.svh"
module lovs_sync
  import lovs_pkg::*;
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic [`LOVS_SYNC_W-1:0] pins_in,
  output logic      [`LOVS_SYNC_W-1:0] pins_sync
);
  import lovs_pkg::*;

  lovs_sync_s r_reg;
  lovs_sync_s r_next;

  // first stage feeds only the second stage
  always_comb
  begin
    r_next      = r_reg;
    r_next.meta = pins_in;
    r_next.sync = r_reg.meta;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign pins_sync = r_reg.sync;

endmodule
`default_nettype wire

//--- testbench/lovs_led_model.sv
// led string voltage model at the far side of the supervisor
`timescale 1ns/1ps
`default_nettype none
module lovs_led_model
#(
  parameter int DISCH_CYCLES = 5
)
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ov_cmd,
  input  wire logic discharge_en,
  output logic      led_ov_trip,
  output logic      led_below_release
);
  logic       high_reg;
  logic [7:0] dis_reg;
  // voltage only falls while the device discharges, so a missing discharge keeps led_below_release low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      high_reg <= 1'b0;
      dis_reg  <= 8'h00;
    end
    else if (ov_cmd)
    begin
      high_reg <= 1'b1;
      dis_reg  <= 8'h00;
    end
    else if (high_reg && discharge_en)
    begin
      dis_reg <= dis_reg + 8'h01;
      if (dis_reg == 8'(DISCH_CYCLES - 1))
        high_reg <= 1'b0;
    end
  end
  assign led_ov_trip       = ov_cmd;
  assign led_below_release = !high_reg;
endmodule
`default_nettype wire

//--- testbench/tb.sv
// self-checking bench of the led overvoltage start-up supervisor
`timescale 1ns/1ps
`default_nettype none
`include "lovs_params.svh"
module tb;
  import lovs_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, d;
  logic        enable_pin, sdi_pin, standalone_mode, supply_above_min, dim_in, batt_ov;
  logic        led_ov_trip, led_below_release, ov_cmd, standby, gm, gd, dis, flag, dither, irq;
  int          n_mismatch;
  int          compares;

  lovs_top #(.HOLD_CYCLES(20), .RECOV_CYCLES(30)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .enable_pin(enable_pin), .sdi_pin(sdi_pin), .standalone_mode(standalone_mode),
    .supply_above_min(supply_above_min), .dim_in(dim_in), .led_ov_trip(led_ov_trip),
    .led_below_release(led_below_release), .batt_ov(batt_ov), .standby(standby),
    .gate_drive_main(gm), .gate_drive_dimming(gd), .discharge_en(dis),
    .ov_recovery_flag(flag), .dither_en(dither), .irq(irq));

  lovs_led_model led (.pclk(pclk), .presetn(presetn), .ov_cmd(ov_cmd), .discharge_en(dis),
    .led_ov_trip(led_ov_trip), .led_below_release(led_below_release));

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until pready is sampled high; data taken at that edge;
  // one idle edge after release so a following call never re-drives psel in the same step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    d       = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic conclude();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic pulses(input int n);
    repeat (n)
    begin
      dim_in <= 1'b1;
      cyc(10);
      dim_in <= 1'b0;
      cyc(10);
    end
  endtask

  initial
  begin
    cyc(5000);
    n_mismatch++;
    conclude();
  end

  initial
  begin
    n_mismatch = 0;
    compares = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {enable_pin, sdi_pin, standalone_mode, supply_above_min, batt_ov, ov_cmd} = '0;
    dim_in = 1'b0;
    cyc(20);
    presetn <= 1'b1;
    cyc(2);
    chk(standby, 1'b1);
    chk(flag, 1'b1);
    apb(1'b0, `LOVS_OFF_CTRL, 32'h0);
    chk(d, 32'h0);
    apb(1'b1, `LOVS_OFF_CTRL, 32'h1);
    apb(1'b0, `LOVS_OFF_CTRL, 32'h0);
    chk(d, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1);
    chk(d, 32'h0);
    cyc(3);
    chk(dither, 1'b1);
    standalone_mode <= 1'b1;
    cyc(5);
    chk(dither, 1'b0);
    sdi_pin <= 1'b1;
    cyc(5);
    chk(dither, 1'b1);
    apb(1'b1, `LOVS_OFF_IRQ_MASK, 32'h1);
    enable_pin <= 1'b1;
    supply_above_min <= 1'b1;
    dim_in <= 1'b1;
    cyc(10);
    chk(standby, 1'b0);
    chk(gm, 1'b0);
    cyc(20);
    chk({gm, gd}, 2'b11);
    chk(flag, 1'b1);
    cyc(35);
    chk(flag, 1'b0);
    ov_cmd <= 1'b1;
    cyc(4);
    chk({gm, gd}, 2'b00);
    chk(dis, 1'b1);
    chk(irq, 1'b1);
    ov_cmd <= 1'b0;
    apb(1'b0, `LOVS_OFF_GSB, 32'h0);
    chk(d, 32'h80);
    cyc(20);
    chk(dis, 1'b0);
    chk(gm, 1'b0);
    apb(1'b0, `LOVS_OFF_SR1, 32'h0);
    chk(d, 32'h40000);
    cyc(5);
    chk(gm, 1'b1);
    apb(1'b0, `LOVS_OFF_SR1, 32'h0);
    chk(d, 32'h0);
    apb(1'b1, `LOVS_OFF_IRQ_STAT, 32'h7);
    cyc(1);
    chk(irq, 1'b0);
    batt_ov <= 1'b1;
    ov_cmd <= 1'b1;
    cyc(8);
    chk(dis, 1'b0);
    apb(1'b0, `LOVS_OFF_GSB, 32'h0);
    chk(d, 32'h0);
    batt_ov <= 1'b0;
    cyc(5);
    chk(dis, 1'b1);
    ov_cmd <= 1'b0;
    cyc(20);
    chk({dis, gm}, 2'b00);
    apb(1'b0, `LOVS_OFF_SR1, 32'h0);
    chk(d, 32'h40000);
    cyc(5);
    chk(gm, 1'b1);
    enable_pin <= 1'b0;
    cyc(5);
    chk({standby, flag, gm}, 3'b110);
    enable_pin <= 1'b1;
    cyc(30);
    ov_cmd <= 1'b1;
    cyc(3);
    ov_cmd <= 1'b0;
    cyc(2);
    chk({dis, flag}, 2'b11);
    cyc(60);
    chk({flag, gm}, 2'b01);
    apb(1'b0, `LOVS_OFF_SR1, 32'h0);
    chk(d, 32'h0);
    supply_above_min <= 1'b0;
    dim_in <= 1'b0;
    cyc(5);
    chk(flag, 1'b1);
    supply_above_min <= 1'b1;
    cyc(60);
    chk({flag, gm}, 2'b10);
    pulses(2);
    chk(flag, 1'b1);
    pulses(2);
    chk(flag, 1'b0);
    apb(1'b1, `LOVS_OFF_IRQ_MASK, 32'h2);
    cyc(1);
    chk(irq, 1'b1);
    apb(1'b1, `LOVS_OFF_IRQ_STAT, 32'h2);
    cyc(1);
    chk(irq, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
